// ===== rtl/epvb_top.sv
/*
  Exception pending/status register and vector table base register
  behind an APB slave, with the pending-vector selection.
  Assumes the exception engine drives handler-entry pulses, the active
  exception number, the active count and all priorities on CLK; only
  the non-maskable request pin is asynchronous.
*/
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "epvb_map.svh"

module epvb_top
  import epvb_pkg::*;
#(
  parameter int NUM_IRQ = 16,
  parameter int PRIO_W = 8,
  parameter int ACT_W = 9
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire logic NMI_IN,
  input wire logic NMI_ENTRY,
  input wire logic DSV_ENTRY,
  input wire logic TICK_ENTRY,
  input wire logic TICK_EVENT,
  input wire logic [NUM_IRQ-1:0] IRQ_PEND,
  input wire logic [NUM_IRQ-1:0] IRQ_EN,
  input wire logic [NUM_IRQ*PRIO_W-1:0] IRQ_PRIO,
  input wire logic [PRIO_W-1:0] DSV_PRIO,
  input wire logic [PRIO_W-1:0] TICK_PRIO,
  input wire logic [PRIO_W-1:0] BASE_PRI,
  input wire logic FAULT_MASK,
  input wire logic DEBUG_HALTED,
  input wire logic DEBUG_BIT,
  input wire logic [8:0] INTERRUPT_PROGRAM_STATUS_EXC,
  input wire logic [ACT_W-1:0] ACTIVE_COUNT,
  output logic NMI_PEND,
  output logic DSV_PEND,
  output logic TICK_PEND,
  output logic [8:0] PEND_VECTOR,
  output logic IRQ_PENDING,
  output logic [31:0] TABLE_OFFSET,
  output logic ACTIVE_IS_IRQ,
  output logic [8:0] ACTIVE_IRQ_INDEX
);

  // ****************************************************************
  // APB request and decode
  // ****************************************************************
  epvb_apb_req_t req;
  epvb_sys_pend_t pend;

  assign req.sel = PSEL;
  assign req.enable = PENABLE;
  assign req.write = PWRITE;
  assign req.addr = PADDR;
  assign req.wdata = PWDATA;
  assign req.strb = PSTRB;

  wire setup_phase = req.sel & ~req.enable;
  wire access_phase = req.sel & req.enable;
  wire hit_pend_ctrl = (req.addr == `EPVB_OFF_PEND_CTRL);
  wire hit_vec_base = (req.addr == `EPVB_OFF_VEC_BASE);
  wire hit_any = hit_pend_ctrl | hit_vec_base;
  wire wr_access = access_phase & req.write;
  wire wr_pend_ctrl = wr_access & hit_pend_ctrl;
  wire wr_vec_base = wr_access & hit_vec_base;

  // Byte-lane mask from the strobes
  logic [31:0] lane_mask;
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign lane_mask[gb*8 +: 8] = {8{req.strb[gb]}};
    end
  endgenerate

  wire [31:0] wr_bits = req.wdata & lane_mask;

  // No wait states; unmapped addresses answer with an error
  assign PREADY = 1'b1;
  assign PSLVERR = access_phase & ~hit_any;

  // ****************************************************************
  // Non-maskable request pin
  // ****************************************************************
  logic nmi_pin_s;
  logic nmi_pin_d;

  epvb_sync2 #(
    .W(1)
  ) u_nmi_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .d(NMI_IN),
    .q(nmi_pin_s)
  );

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      nmi_pin_d <= 1'b0;
    end else begin
      nmi_pin_d <= nmi_pin_s;
    end
  end

  // Only a fresh assertion re-pends, so a held pin cannot lock the
  // handler into endless re-entry
  wire nmi_pin_rise = nmi_pin_s & ~nmi_pin_d;

  // ****************************************************************
  // Pending flags
  // ****************************************************************
  wire nmi_set = (wr_pend_ctrl & wr_bits[`EPVB_B_NMI_SET])
                 | nmi_pin_rise;
  wire dsv_set = wr_pend_ctrl & wr_bits[`EPVB_B_DSV_SET];
  wire dsv_clr = (wr_pend_ctrl & wr_bits[`EPVB_B_DSV_CLR])
                 | DSV_ENTRY;
  wire tick_set = (wr_pend_ctrl & wr_bits[`EPVB_B_TICK_SET])
                  | TICK_EVENT;
  wire tick_clr = (wr_pend_ctrl & wr_bits[`EPVB_B_TICK_CLR])
                  | TICK_ENTRY;

  // Handler entry clears; a new pin edge in the same cycle wins
  epvb_pend_bit u_nmi_pend (
    .clk(CLK),
    .rst_n(RST_N),
    .set_req(nmi_set),
    .clr_req(NMI_ENTRY),
    .pend(pend.nmi)
  );

  // Set-and-clear in one write is software's fault; set wins here
  epvb_pend_bit u_dsv_pend (
    .clk(CLK),
    .rst_n(RST_N),
    .set_req(dsv_set),
    .clr_req(dsv_clr),
    .pend(pend.dsv)
  );

  epvb_pend_bit u_tick_pend (
    .clk(CLK),
    .rst_n(RST_N),
    .set_req(tick_set),
    .clr_req(tick_clr),
    .pend(pend.tick)
  );

  assign NMI_PEND = pend.nmi;
  assign DSV_PEND = pend.dsv;
  assign TICK_PEND = pend.tick;

  // ****************************************************************
  // Vector table base
  // ****************************************************************
  logic [`EPVB_TBL_W-1:0] tbl_off;

  wire [31:0] vec_base_img = {tbl_off, 9'h000};
  wire [31:0] vec_base_new = (vec_base_img & ~lane_mask) | wr_bits;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tbl_off <= `EPVB_TBL_RST;
    end else if (wr_vec_base) begin
      // Low nine bits are dropped, never stored
      tbl_off <= vec_base_new[`EPVB_B_TBL_HI:`EPVB_B_TBL_LO];
    end
  end

  // Field holds offset bits 29..7 above address zero; alignment is
  // left to software
  assign TABLE_OFFSET = {2'b00, tbl_off, 7'h00};

  // ****************************************************************
  // Pending-vector selection
  // ****************************************************************
  logic [PRIO_W-1:0] irq_prio [NUM_IRQ];
  logic [NUM_IRQ-1:0] irq_ok;

  wire base_off = (BASE_PRI == '0);
  wire dsv_ok = pend.dsv & ~FAULT_MASK
                & (base_off | (DSV_PRIO < BASE_PRI));
  wire tick_ok = pend.tick & ~FAULT_MASK
                 & (base_off | (TICK_PRIO < BASE_PRI));

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
      assign irq_prio[gi] = IRQ_PRIO[gi*PRIO_W +: PRIO_W];
      // Primary mask deliberately plays no part here
      assign irq_ok[gi] = IRQ_PEND[gi] & IRQ_EN[gi] & ~FAULT_MASK
                          & (base_off | (irq_prio[gi] < BASE_PRI));
    end
  endgenerate

  logic [8:0] next_pend_vec;
  logic [PRIO_W-1:0] best_pri;
  logic best_found;

  // Ascending exception numbers with strict compare: equal priority
  // goes to the lower number
  always_comb begin
    next_pend_vec = `EPVB_EXC_NONE;
    best_pri = '0;
    best_found = 1'b0;
    if (dsv_ok) begin
      next_pend_vec = `EPVB_EXC_DSV;
      best_pri = DSV_PRIO;
      best_found = 1'b1;
    end
    if (tick_ok && (!best_found || TICK_PRIO < best_pri)) begin
      next_pend_vec = `EPVB_EXC_TICK;
      best_pri = TICK_PRIO;
      best_found = 1'b1;
    end
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (irq_ok[i] && (!best_found || irq_prio[i] < best_pri)) begin
        next_pend_vec = `EPVB_EXC_IRQ_BASE + 9'(i);
        best_pri = irq_prio[i];
        best_found = 1'b1;
      end
    end
    // Non-maskable outranks everything and ignores both masks
    if (pend.nmi) begin
      next_pend_vec = `EPVB_EXC_NMI;
    end
  end

  // ****************************************************************
  // Status registers
  // ****************************************************************
  logic [8:0] next_irq_index;

  assign next_irq_index = INTERRUPT_PROGRAM_STATUS_EXC - `EPVB_EXC_IRQ_BASE;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PEND_VECTOR <= `EPVB_EXC_NONE;
      IRQ_PENDING <= 1'b0;
      ACTIVE_IS_IRQ <= 1'b0;
      ACTIVE_IRQ_INDEX <= 9'h000;
    end else begin
      PEND_VECTOR <= next_pend_vec;
      IRQ_PENDING <= |IRQ_PEND;
      ACTIVE_IS_IRQ <= (INTERRUPT_PROGRAM_STATUS_EXC >= `EPVB_EXC_IRQ_BASE);
      ACTIVE_IRQ_INDEX <= (INTERRUPT_PROGRAM_STATUS_EXC >= `EPVB_EXC_IRQ_BASE) ?
                          next_irq_index : 9'h000;
    end
  end

  wire dbg_bit = DEBUG_HALTED & DEBUG_BIT;
  wire rtb_bit = (ACTIVE_COUNT <= ACT_W'(1));

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Write-only clear bits and reserved positions read zero
  wire [31:0] rd_pend_ctrl = {
    pend.nmi, 2'b00, pend.dsv, 1'b0, pend.tick, 1'b0, 1'b0,
    dbg_bit, IRQ_PENDING, 1'b0, PEND_VECTOR, rtb_bit, 2'b00,
    INTERRUPT_PROGRAM_STATUS_EXC
  };

  wire [31:0] rd_sel = hit_pend_ctrl ? rd_pend_ctrl :
                       hit_vec_base ? vec_base_img :
                       `EPVB_RDATA_RST;

  // Captured in the setup cycle so the data come from a flop
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PRDATA <= `EPVB_RDATA_RST;
    end else if (setup_phase & ~req.write) begin
      PRDATA <= rd_sel;
    end
  end

endmodule // epvb_top

// ===== common/epvb_map.svh
/*
  Offsets, bit positions, exception numbers and reset values of the
  exception pending/status register and the vector table base register.
  Assumes a 12-bit APB byte address space and 32-bit register words.
*/
`ifndef EPVB_MAP_SVH
`define EPVB_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define EPVB_OFF_PEND_CTRL 12'h004
`define EPVB_OFF_VEC_BASE 12'h008

// ****************************************************************
// Pending/status register fields
// ****************************************************************
`define EPVB_B_NMI_SET 31
`define EPVB_B_DSV_SET 28
`define EPVB_B_DSV_CLR 27
`define EPVB_B_TICK_SET 26
`define EPVB_B_TICK_CLR 25
`define EPVB_B_DBG 23
`define EPVB_B_IRQ_PEND 22
`define EPVB_B_PV_HI 20
`define EPVB_B_PV_LO 12
`define EPVB_B_RTB 11
`define EPVB_B_AV_HI 8
`define EPVB_B_AV_LO 0

// ****************************************************************
// Vector base register fields
// ****************************************************************
`define EPVB_B_TBL_HI 31
`define EPVB_B_TBL_LO 9
`define EPVB_TBL_W 23
`define EPVB_TBL_RST 23'h000000

// ****************************************************************
// Exception numbers
// ****************************************************************
`define EPVB_EXC_NONE 9'h000
`define EPVB_EXC_NMI 9'h002
`define EPVB_EXC_DSV 9'h00E
`define EPVB_EXC_TICK 9'h00F
`define EPVB_EXC_IRQ_BASE 9'h010

`define EPVB_RDATA_RST 32'h00000000

`endif

// ===== common/epvb_pkg.sv
/*
  Types shared by the exception pending/vector base block.
  Assumes the map header for all numeric constants.
*/
package epvb_pkg;

  // APB request fields as they arrive at the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
  } epvb_apb_req_t;

  // Pending state of the three system exceptions kept here
  typedef struct packed {
    logic nmi;
    logic dsv;
    logic tick;
  } epvb_sys_pend_t;

endpackage

// ===== rtl/epvb_sync2.sv
/*
  Two-flop synchroniser for levels from outside the clock domain.
  Assumes the input changes slowly relative to CLK.
*/
`timescale 1ns/10ps
module epvb_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // epvb_sync2

// ===== rtl/epvb_pend_bit.sv
/*
  One sticky pending flag with a set and a clear request.
  Assumes both requests are single-cycle terms on the same clock.
*/
`timescale 1ns/10ps
module epvb_pend_bit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set_req,
  input wire logic clr_req,
  output logic pend
);

  // Set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend <= 1'b0;
    end else if (set_req) begin
      pend <= 1'b1;
    end else if (clr_req) begin
      pend <= 1'b0;
    end
  end

endmodule // epvb_pend_bit

// ===== tb/epvb_top_monitor.sv
/*
  Checker for epvb_top: APB answer, pend flags, table offset, index.
  Assumes it is bound to epvb_top and sees only its ports.
*/
`timescale 1ns/10ps
`include "epvb_map.svh"
module epvb_top_monitor (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic NMI_IN,
  input wire logic NMI_ENTRY,
  input wire logic TICK_ENTRY,
  input wire logic TICK_EVENT,
  input wire logic NMI_PEND,
  input wire logic DSV_PEND,
  input wire logic TICK_PEND,
  input wire logic [31:0] TABLE_OFFSET,
  input wire logic [8:0] INTERRUPT_PROGRAM_STATUS_EXC,
  input wire logic [8:0] ACTIVE_IRQ_INDEX
);
  // ****************************************************************
  // Decode
  // ****************************************************************
  wire acc = PSEL && PENABLE;
  wire pc = PADDR == `EPVB_OFF_PEND_CTRL;
  wire mapped = pc || PADDR == `EPVB_OFF_VEC_BASE;
  wire pc_wr = acc && PWRITE && PSTRB[3] && pc;
  wire vb_wr = acc && PWRITE && PSTRB[3] && PADDR == `EPVB_OFF_VEC_BASE;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // Pin must stay high long enough to pass the two-flop synchroniser
  sequence s_nmi_rise;
    !NMI_IN ##1 (NMI_IN && !NMI_ENTRY) [*4];
  endsequence
  // ****************************************************************
  // Properties
  // ****************************************************************
  a_ready_high: assert property (PREADY)
    else $error("ready low");
  a_err_unmapped: assert property (acc && !mapped |-> PSLVERR)
    else $error("no error on unmapped");
  a_err_mapped: assert property (acc && mapped |-> !PSLVERR)
    else $error("error on mapped");
  a_nmi_sw_set: assert property (pc_wr && PWDATA[31] |=> NMI_PEND)
    else $error("nmi not set");
  a_nmi_pin_set: assert property (s_nmi_rise |-> NMI_PEND)
    else $error("nmi pin lost");
  a_nmi_entry_clr: assert property (!NMI_IN [*4] ##0 NMI_ENTRY
    && !(pc_wr && PWDATA[31]) |=> !NMI_PEND)
    else $error("nmi not cleared");
  a_dsv_set: assert property (pc_wr && PWDATA[28] |=> DSV_PEND)
    else $error("dsv not set");
  a_dsv_source: assert property ($rose(DSV_PEND) |->
    $past(pc_wr && PWDATA[28]))
    else $error("dsv set by hardware");
  a_dsv_clear: assert property (pc_wr && PWDATA[27] && !PWDATA[28]
    |=> !DSV_PEND)
    else $error("dsv not cleared");
  a_tick_event: assert property (TICK_EVENT |=> TICK_PEND)
    else $error("tick not set");
  a_tick_clear: assert property ((TICK_ENTRY || pc_wr && PWDATA[25])
    && !TICK_EVENT && !(pc_wr && PWDATA[26]) |=> !TICK_PEND)
    else $error("tick not cleared");
  a_tbl_offset: assert property (vb_wr |=>
    TABLE_OFFSET[31:23] == {2'b00, $past(PWDATA[31:25])})
    else $error("offset mismatch");
  a_active_index: assert property ($past(RST_N) |-> ACTIVE_IRQ_INDEX ==
    ($past(INTERRUPT_PROGRAM_STATUS_EXC) >= 9'h010 ? $past(INTERRUPT_PROGRAM_STATUS_EXC) - 9'h010 : 9'h000))
    else $error("index mismatch");
endmodule // epvb_top_monitor

bind epvb_top epvb_top_monitor u_mon (.CLK(CLK), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .NMI_IN(NMI_IN), .NMI_ENTRY(NMI_ENTRY), .TICK_ENTRY(TICK_ENTRY),
  .TICK_EVENT(TICK_EVENT), .NMI_PEND(NMI_PEND), .DSV_PEND(DSV_PEND),
  .TICK_PEND(TICK_PEND), .TABLE_OFFSET(TABLE_OFFSET), .INTERRUPT_PROGRAM_STATUS_EXC(INTERRUPT_PROGRAM_STATUS_EXC),
  .ACTIVE_IRQ_INDEX(ACTIVE_IRQ_INDEX));

// ===== tb/tb.sv
/*
  Testbench for epvb_top: APB reads compared with a reference model.
  Assumes the map header and a 25 MHz clock.
*/
`timescale 1ns/10ps
`include "epvb_map.svh"
module tb
  import epvb_pkg::*;
;
  logic CLK, RST_N, rerr, perr, pready, act_irq, ipend;
  logic fault_mask, dbg_halt, dbg_bit, m_nmi, m_dsv, m_tick;
  epvb_apb_req_t q;
  logic [4:0] ev;
  logic [15:0] irq_pend, irq_en;
  logic [127:0] irq_prio;
  logic [7:0] dsv_prio, tick_prio, base_pri;
  logic [8:0] interrupt_program_status, act_cnt, pvec;
  logic [31:0] seed, rdat, m_vb, prdata, tbl, r;
  int errors, check_count;

  epvb_top dut (.CLK(CLK), .RST_N(RST_N), .PSEL(q.sel), .PENABLE(q.enable),
    .PWRITE(q.write), .PADDR(q.addr), .PWDATA(q.wdata), .PSTRB(q.strb),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(perr), .NMI_IN(ev[4]),
    .NMI_ENTRY(ev[3]), .DSV_ENTRY(ev[2]), .TICK_ENTRY(ev[1]),
    .TICK_EVENT(ev[0]), .IRQ_PEND(irq_pend), .IRQ_EN(irq_en),
    .IRQ_PRIO(irq_prio), .DSV_PRIO(dsv_prio), .TICK_PRIO(tick_prio),
    .BASE_PRI(base_pri), .FAULT_MASK(fault_mask), .DEBUG_HALTED(dbg_halt),
    .DEBUG_BIT(dbg_bit), .INTERRUPT_PROGRAM_STATUS_EXC(interrupt_program_status), .ACTIVE_COUNT(act_cnt),
    .NMI_PEND(), .DSV_PEND(), .TICK_PEND(), .PEND_VECTOR(pvec),
    .IRQ_PENDING(ipend),
    .TABLE_OFFSET(tbl), .ACTIVE_IS_IRQ(act_irq), .ACTIVE_IRQ_INDEX());

  // ****************************************************************
  // Model and helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Ascending scan with strict compare gives ties to the lower number
  function automatic logic [31:0] exp_pc();
    logic [8:0] pv;
    logic [8:0] bp;
    logic [7:0] pr;
    logic p;
    pv = 9'h000;
    bp = 9'h100;
    for (int j = 0; j < 18; j++) begin
      pr = j == 0 ? dsv_prio : j == 1 ? tick_prio : irq_prio[8*(j-2)+:8];
      p = j == 0 ? m_dsv : j == 1 ? m_tick : irq_pend[j-2] & irq_en[j-2];
      if (p && {1'b0, pr} < bp && (base_pri == 8'h00 || pr < base_pri)) begin
        bp = {1'b0, pr};
        pv = 9'(j + 14);
      end
    end
    if (fault_mask)
      pv = 9'h000;
    if (m_nmi)
      pv = `EPVB_EXC_NMI;
    return {m_nmi, 2'b00, m_dsv, 1'b0, m_tick, 2'b00, dbg_halt & dbg_bit,
      |irq_pend, 1'b0, pv, act_cnt <= 9'h001, 2'b00, interrupt_program_status};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s);
    @(posedge CLK);
    q <= '{1'b1, 1'b0, w, a, d, s};
    @(posedge CLK);
    q.enable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge CLK);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = perr;
    q <= '0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x,
    input logic xe);
    repeat (3) @(posedge CLK);
    apb(1'b0, a, 32'h00000000, 4'hF);
    chk(rdat, x);
    chk(rerr, xe);
  endtask

  task automatic wr_pc(input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, `EPVB_OFF_PEND_CTRL, d, s);
    if (s[3]) begin
      m_nmi = m_nmi | d[31];
      m_dsv = d[28] | (m_dsv & ~d[27]);
      m_tick = d[26] | (m_tick & ~d[25]);
    end
  endtask

  task automatic wr_vb(input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, `EPVB_OFF_VEC_BASE, d, s);
    for (int i = 0; i < 4; i++)
      if (s[i])
        m_vb[8*i+:8] = d[8*i+:8];
    m_vb[8:0] = 9'h000;
  endtask

  task automatic pulse(input logic [4:0] p, input int n);
    @(posedge CLK);
    ev <= p;
    repeat (n) @(posedge CLK);
    ev <= 5'h00;
  endtask

  task automatic test_done();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    test_done();
  end

  initial begin
    {RST_N, q, ev, irq_pend, irq_en, irq_prio, dsv_prio, tick_prio} = '0;
    {base_pri, fault_mask, dbg_halt, dbg_bit, interrupt_program_status, act_cnt} = '0;
    {m_nmi, m_dsv, m_tick, m_vb, errors, check_count} = '0;
    seed = 32'h00017315;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    rd_chk(`EPVB_OFF_PEND_CTRL, 32'h00000800, 1'b0);
    rd_chk(`EPVB_OFF_VEC_BASE, 32'h00000000, 1'b0);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF, 4'hF);
    chk(rerr, 1'b1);
    rd_chk(12'h00C, 32'h00000000, 1'b1);
    wr_pc(32'h94000000, 4'h7);
    rd_chk(`EPVB_OFF_PEND_CTRL, exp_pc(), 1'b0);
    wr_pc(32'h94000000, 4'hF);
    rd_chk(`EPVB_OFF_PEND_CTRL, exp_pc(), 1'b0);
    pulse(5'h08, 1);
    m_nmi = 1'b0;
    rd_chk(`EPVB_OFF_PEND_CTRL, exp_pc(), 1'b0);
    pulse(5'h06, 1);
    {m_dsv, m_tick} = 2'b00;
    rd_chk(`EPVB_OFF_PEND_CTRL, exp_pc(), 1'b0);
    pulse(5'h01, 1);
    m_tick = 1'b1;
    rd_chk(`EPVB_OFF_PEND_CTRL, exp_pc(), 1'b0);
    pulse(5'h10, 4);
    m_nmi = 1'b1;
    rd_chk(`EPVB_OFF_PEND_CTRL, exp_pc(), 1'b0);
    for (int k = 0; k < 60; k++) begin
      if (m_nmi)
        pulse(5'h08, 1);
      m_nmi = 1'b0;
      r = rnd();
      irq_pend <= r[15:0];
      irq_en <= r[31:16];
      irq_prio <= {rnd(), rnd(), rnd(), rnd()};
      r = rnd();
      {dsv_prio, tick_prio} <= r[15:0];
      base_pri <= r[16] ? r[31:24] : 8'h00;
      {fault_mask, dbg_halt, dbg_bit} <= {&r[18:17], r[19], r[20]};
      interrupt_program_status <= r[8:0];
      act_cnt <= {7'h00, r[22:21]};
      r = rnd();
      r[31] = &r[31:29];
      r[27] = r[27] & ~r[28];
      r[25] = r[25] & ~r[26];
      wr_pc(r, r[7:4]);
      r = rnd();
      wr_vb(r, r[3:0]);
      rd_chk(`EPVB_OFF_PEND_CTRL, exp_pc(), 1'b0);
      rd_chk(`EPVB_OFF_VEC_BASE, m_vb, 1'b0);
      chk(tbl, {2'b00, m_vb[31:9], 7'h00});
      chk(act_irq, interrupt_program_status >= `EPVB_EXC_IRQ_BASE);
      r = exp_pc();
      chk(pvec, r[20:12]);
      chk(ipend, r[22]);
    end
    test_done();
  end
endmodule // tb
